// [src/arb_pkg.sv]
// Package with timing constants and state codes for the bus arbiter
`default_nettype none
package arb_pkg;
  // ************************************************
  // Timing
  // ************************************************
  localparam int unsigned CLK_PERIOD_PS   = 10000;
  localparam int unsigned GRANT_MIN_HALF  = 3;
  localparam int unsigned GRANT_MAX_HALF  = 7;
  localparam int unsigned STROBE_GAP_HALF = 3;
  localparam int unsigned FC_GAP_CLKS     = 1;
  // Half periods rounded up to whole cycles for least times
  localparam int unsigned STROBE_GAP_CYC  = (STROBE_GAP_HALF + 1) / 2;
  localparam int unsigned FC_GAP_CYC      = FC_GAP_CLKS;
  localparam logic [1:0]  GAP_STROBE      = 2'(STROBE_GAP_CYC);
  localparam logic [1:0]  GAP_FC          = 2'(FC_GAP_CYC);
  localparam logic [1:0]  GAP_ZERO        = 2'h0;
  localparam logic [1:0]  GAP_ONE         = 2'h1;

  // ************************************************
  // States
  // ************************************************
  typedef enum logic [4:0] {
    ST_OWN     = 5'h01,
    ST_WAITEND = 5'h02,
    ST_GRANT   = 5'h04,
    ST_EXTERN  = 5'h08,
    ST_RECOVER = 5'h10
  } arb_state_t;
endpackage
`default_nettype wire

// [src/arb_sync_if.sv]
// Interface carrying synchronised arbitration inputs
`default_nettype none
interface arb_sync_if;
  logic req_n_s;
  logic ack_n_s;
  modport src (output req_n_s, output ack_n_s);
  modport dst (input req_n_s, input ack_n_s);
endinterface
`default_nettype wire

// [src/arb_sync.sv]
// Two-stage synchronisers for request and acknowledge
`default_nettype none
module arb_sync (
  input  wire logic   ref_clk,
  input  wire logic   rst_n,
  input  wire logic   bus_request_n,
  input  wire logic   grant_acknowledge_n,
  arb_sync_if.src     sync
);
  logic [1:0] s1_q;
  logic [1:0] s1_d;
  logic [1:0] s2_q;
  logic [1:0] s2_d;

  // ************************************************
  // Synchroniser
  // ************************************************
  // two flop stages
  always_comb begin
    s1_d = {grant_acknowledge_n, bus_request_n};
    s2_d = s1_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_q <= 2'h3;
      s2_q <= 2'h3;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign sync.req_n_s = s2_q[0];
  assign sync.ack_n_s = s2_q[1];
endmodule
`default_nettype wire

// [src/cpu_bus_arbitration.sv]
// Bus arbitration logic of the processor bus interface
// Behaviour
// - Grant follows a request asserted by 1.5 to 3.5 clock periods.
// - Grant drops 1.5 to 3.5 periods after a request withdrawn under grant.
// - Grant drops 1.5 to 3.5 periods after acknowledge is asserted.
// - A request still held after that window may be granted again.
// - A request withdrawn before any ack returns the bus to the processor.
// - Strobes and read/write stay off 1.5 periods after ack release.
// - Function code and valid address stay off 1 period after ack release.
// - Strobes and read/write stay off 1.5 periods after a bare withdrawal.
// - Function code and valid address stay off 1 period then too.
// - With grant given and the strobe negated the bus floats.
`default_nettype none
module cpu_bus_arbitration (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic bus_request_n,
  input  wire logic grant_acknowledge_n,
  input  wire logic address_strobe_n,
  output logic      bus_grant_n,
  output logic      strobe_drive_en,
  output logic      fc_drive_en,
  output logic      bus_drive_en,
  output logic      bus_owned
);
  arb_sync_if sync ();

  arb_sync u_sync (
    .ref_clk             (ref_clk),
    .rst_n               (rst_n),
    .bus_request_n       (bus_request_n),
    .grant_acknowledge_n (grant_acknowledge_n),
    .sync                (sync)
  );

  arb_pkg::arb_state_t state_q;
  arb_pkg::arb_state_t state_d;
  logic [1:0]          gap_q;
  logic [1:0]          gap_d;
  logic                grant_q;
  logic                grant_d;
  logic                sdrv_q;
  logic                sdrv_d;
  logic                fdrv_q;
  logic                fdrv_d;
  logic                bdrv_q;
  logic                bdrv_d;
  logic                late_q;
  logic                late_d;
  logic                owned_q;
  logic                owned_d;

  // ************************************************
  // Synchronised inputs
  // ************************************************
  logic req;
  logic ack;
  assign req = ~sync.req_n_s;
  assign ack = ~sync.ack_n_s;

  // ************************************************
  // Arbitration state machine
  // ************************************************
  always_comb begin
    state_d = state_q;
    gap_d   = gap_q;
    grant_d = grant_q;
    sdrv_d  = sdrv_q;
    fdrv_d  = fdrv_q;
    bdrv_d  = bdrv_q;
    case (state_q)
      arb_pkg::ST_OWN: begin
        sdrv_d = 1'b1;
        fdrv_d = 1'b1;
        bdrv_d = 1'b1;
        if (req) begin
          grant_d = 1'b1;
          state_d = arb_pkg::ST_WAITEND;
        end
      end
      arb_pkg::ST_WAITEND: begin
        if (!req && !ack) begin
          grant_d = 1'b0;
          gap_d   = arb_pkg::GAP_STROBE;
          state_d = arb_pkg::ST_RECOVER;
        end else if (ack) begin
          grant_d = 1'b0;
          state_d = arb_pkg::ST_EXTERN;
        end else if (address_strobe_n) begin
          sdrv_d  = 1'b0;
          fdrv_d  = 1'b0;
          bdrv_d  = 1'b0;
          state_d = arb_pkg::ST_GRANT;
        end
      end
      arb_pkg::ST_GRANT: begin
        if (ack) begin
          grant_d = 1'b0;
          state_d = arb_pkg::ST_EXTERN;
        end else if (!req) begin
          grant_d = 1'b0;
          gap_d   = arb_pkg::GAP_STROBE;
          state_d = arb_pkg::ST_RECOVER;
        end
      end
      arb_pkg::ST_EXTERN: begin
        sdrv_d = 1'b0;
        fdrv_d = 1'b0;
        bdrv_d = 1'b0;
        if (req && late_q && !grant_q) begin
          grant_d = 1'b1;
        end else if (!req && grant_q) begin
          grant_d = 1'b0;
        end
        if (!ack) begin
          grant_d = 1'b0;
          gap_d   = arb_pkg::GAP_STROBE;
          state_d = arb_pkg::ST_RECOVER;
        end
      end
      arb_pkg::ST_RECOVER: begin
        if (gap_q != arb_pkg::GAP_ZERO) begin
          gap_d = gap_q - arb_pkg::GAP_ONE;
        end
        if (gap_q <= arb_pkg::GAP_STROBE - arb_pkg::GAP_FC) begin
          fdrv_d = 1'b1;
        end
        if (gap_q == arb_pkg::GAP_ZERO) begin
          sdrv_d  = 1'b1;
          bdrv_d  = 1'b1;
          state_d = arb_pkg::ST_OWN;
        end
      end
      default: begin
        state_d = arb_pkg::ST_OWN;
        grant_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= arb_pkg::ST_OWN;
      gap_q   <= arb_pkg::GAP_ZERO;
      grant_q <= 1'b0;
      sdrv_q  <= 1'b1;
      fdrv_q  <= 1'b1;
      bdrv_q  <= 1'b1;
    end else begin
      state_q <= state_d;
      gap_q   <= gap_d;
      grant_q <= grant_d;
      sdrv_q  <= sdrv_d;
      fdrv_q  <= fdrv_d;
      bdrv_q  <= bdrv_d;
    end
  end

  // ************************************************
  // Late request flag
  // ************************************************
  // request held past hand-over
  always_comb begin
    late_d = 1'b0;
    if (state_q == arb_pkg::ST_EXTERN) begin
      late_d = req;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      late_q <= 1'b0;
    end else begin
      late_q <= late_d;
    end
  end

  // ************************************************
  // Owner flag
  // ************************************************
  // processor owns bus again
  always_comb begin
    owned_d = 1'b0;
    if (state_d == arb_pkg::ST_OWN) begin
      owned_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      owned_q <= 1'b1;
    end else begin
      owned_q <= owned_d;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign bus_grant_n     = ~grant_q;
  assign strobe_drive_en = sdrv_q;
  assign fc_drive_en     = fdrv_q;
  assign bus_drive_en    = bdrv_q;
  assign bus_owned       = owned_q;
endmodule
`default_nettype wire

// [verif/arb_master.sv]
// Model of the external bus master
`default_nettype none
module arb_master (
  input  wire logic ref_clk,
  input  wire logic bus_grant_n,
  output var  logic bus_request_n,
  output var  logic grant_acknowledge_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    bus_request_n = 1'b1;
    grant_acknowledge_n = 1'b1;
  end
  task automatic ask(output int lat);
    lat = 0;
    @(posedge ref_clk) #1 bus_request_n = 1'b0;
    while (bus_grant_n !== 1'b0 && lat < 20) begin
      @(posedge ref_clk) #1 lat++;
    end
  endtask
  task automatic take(input int hold, output int lat);
    lat = 0;
    grant_acknowledge_n = 1'b0;
    @(posedge ref_clk) #1 bus_request_n = 1'b1;
    for (int n = 1; n <= hold || n <= 3; n++) begin
      @(posedge ref_clk);
      #1;
      if (lat == 0 && bus_grant_n === 1'b1) lat = n + 1;
      if (n == hold) grant_acknowledge_n = 1'b1;
    end
  endtask
  // Sets request and acknowledge together
  task automatic put(input logic req_v, input logic ack_v);
    bus_request_n       = req_v;
    grant_acknowledge_n = ack_v;
  endtask
endmodule
`default_nettype wire

// [verif/cpu_bus_arbitration_chk.sv]
// Port assertions for the bus arbiter
`default_nettype none
module cpu_bus_arbitration_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic bus_request_n,
  input wire logic grant_acknowledge_n,
  input wire logic address_strobe_n,
  input wire logic bus_grant_n,
  input wire logic strobe_drive_en,
  input wire logic fc_drive_en,
  input wire logic bus_drive_en,
  input wire logic bus_owned
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_req_grant: assert property ($fell(bus_request_n) |->
    ##[1:3] (!bus_grant_n || bus_request_n)) else $error("late grant");
  chk_wd_drop: assert property ($rose(bus_request_n) &&
    !bus_grant_n && grant_acknowledge_n |-> ##[1:3] bus_grant_n)
    else $error("grant held");
  chk_ack_drop: assert property ($fell(grant_acknowledge_n) |->
    ##[1:3] bus_grant_n) else $error("grant after ack");
  chk_wd_resume: assert property ($rose(bus_request_n) &&
    grant_acknowledge_n |-> ##[3:10] (bus_owned && bus_grant_n))
    else $error("no resume");
  chk_ack_strobe: assert property ($rose(grant_acknowledge_n) |->
    !strobe_drive_en [*2] ##[1:6] strobe_drive_en) else $error("strobe");
  chk_ack_fc: assert property ($rose(grant_acknowledge_n) |->
    !fc_drive_en ##1 !fc_drive_en) else $error("fc early");
  chk_wd_strobe: assert property ($rose(bus_request_n) &&
    grant_acknowledge_n && !strobe_drive_en |-> !strobe_drive_en [*2])
    else $error("strobe early");
  chk_wd_fc: assert property ($rose(bus_request_n) &&
    grant_acknowledge_n && !fc_drive_en |-> !fc_drive_en ##1 !fc_drive_en)
    else $error("fc early");
  chk_bus_float: assert property (!bus_grant_n && address_strobe_n
    |-> ##[1:2] !bus_drive_en) else $error("bus not floated");
  chk_sync_delay: assert property ($fell(bus_request_n) &&
    bus_grant_n |=> bus_grant_n) else $error("unsynced grant");
  cover property ($fell(bus_grant_n));
  cover property ($rose(grant_acknowledge_n));
  cover property ($rose(bus_request_n) && !bus_grant_n);
  cover property (!grant_acknowledge_n && $fell(bus_grant_n));
endmodule
bind cpu_bus_arbitration cpu_bus_arbitration_chk chk_i (.ref_clk, .rst_n,
  .bus_request_n, .grant_acknowledge_n, .address_strobe_n, .bus_grant_n,
  .strobe_drive_en, .fc_drive_en, .bus_drive_en, .bus_owned);
`default_nettype wire

// [verif/cpu_bus_arbitration_bench.sv]
// Testbench for the bus arbiter
`default_nettype none
module cpu_bus_arbitration_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic as_n = 1'b1;
  wire  req_n, ack_n, grant_n, sde, fde, bde, own;
  int   err_count = 0;
  int   n_tests = 0;
  int   lat;
  always #5 ref_clk = ~ref_clk;
  arb_master m (.ref_clk, .bus_grant_n(grant_n),
    .bus_request_n(req_n), .grant_acknowledge_n(ack_n));
  cpu_bus_arbitration uut (.ref_clk, .rst_n, .bus_request_n(req_n),
    .grant_acknowledge_n(ack_n), .address_strobe_n(as_n),
    .bus_grant_n(grant_n), .strobe_drive_en(sde), .fc_drive_en(fde),
    .bus_drive_en(bde), .bus_owned(own));
  task automatic chk(input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Grant, float once strobe ends, ack, recover
  task automatic acked(input logic busy, input int hold);
    as_n = ~busy;
    m.ask(lat);
    chk(lat inside {[2:3]}, 1'b1);
    repeat (3) @(posedge ref_clk);
    #1 chk(bde, busy);
    as_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk(bde | fde | sde, 1'b0);
    m.take(hold, lat);
    chk(lat inside {[2:3]}, 1'b1);
    chk(grant_n, 1'b1);
    @(posedge ref_clk) #1 chk(fde | sde, 1'b0);
    repeat (8) @(posedge ref_clk);
    #1 chk(sde & fde & bde & own, 1'b1);
    $display("Acknowledged hand-over done");
  endtask
  // Request withdrawn under grant without ack
  task automatic withdraw();
    m.ask(lat);
    repeat (3) @(posedge ref_clk);
    #1 force_free();
    lat = 0;
    while (grant_n !== 1'b1 && lat < 20) begin
      @(posedge ref_clk) #1 lat++;
    end
    chk(lat inside {[2:3]}, 1'b1);
    chk(fde, 1'b0);
    repeat (8) @(posedge ref_clk);
    #1 chk(own & sde, 1'b1);
    $display("Withdrawal done");
  endtask
  task automatic force_free();
    m.put(1'b1, 1'b1);
  endtask
  // Request held past the hand-over window, then withdrawn
  task automatic regrant();
    m.ask(lat);
    repeat (2) @(posedge ref_clk);
    #1 m.put(1'b0, 1'b0);
    repeat (3) @(posedge ref_clk);
    #1 chk(grant_n, 1'b1);
    repeat (2) @(posedge ref_clk);
    #1 chk(grant_n, 1'b0);
    m.put(1'b1, 1'b0);
    lat = 0;
    while (grant_n !== 1'b1 && lat < 20) begin
      @(posedge ref_clk) #1 lat++;
    end
    chk(lat inside {[2:3]}, 1'b1);
    m.put(1'b1, 1'b1);
    repeat (8) @(posedge ref_clk);
    #1 chk(sde & fde & bde & own, 1'b1);
    $display("Regrant done");
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    acked(1'b0, 5);
    acked(1'b1, 1);
    withdraw();
    regrant();
    acked(1'b1, 2);
    conclude();
  end
  initial begin
    #20000 err_count++;
    conclude();
  end
endmodule
`default_nettype wire
